// File: rbc_top.sv
`timescale 1ns/10ps
// Behaviour
// - bits 6:5 pick 8/16/32/64 byte wrap
// - bit 4 zero enables wrap after reset
// - wrap only for quad io style reads
// - bits 3:0 give latency code after reset
// - latency sits between address/mode and data
// - register-type reads use one dummy cycle
// - other variable reads: code zero means eight
// - reset copies stored value into working copy
// - mode cycles are not latency cycles
module rbc_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic RELOAD,
   input wire logic SCK,
   input wire logic LNK_CMD_VALID,
   input wire logic [7:0] LNK_OPCODE,
   input wire logic [7:0] LNK_WDATA,
   input wire logic LNK_ADDR_DONE,
   output logic LNK_BUSY,
   output logic [4:0] LNK_DUMMY,
   output logic [2:0] LNK_MODE,
   output logic LNK_WRAP,
   output logic [6:0] LNK_WRAP_BYTES,
   output logic LNK_DATA_GO,
   output logic [7:0] REG_RDATA,
   output logic WRAP_ENABLE,
   output logic [6:0] WRAP_BYTES,
   output logic [3:0] READ_LATENCY,
   output logic WRITE_ENABLED
);
   ////////////////////////////////////////////////////////////////////////////
   // crossings
   logic req_tgl_q; // link side: toggles per register command
   logic req_sync; // req toggle seen in CLK domain
   logic ack_tgl_q; // CLK side: toggles when a command is applied
   logic vx_tgl_q; // CLK side: toggles when working copy reloads
   logic [2:0] to_lnk; // {ce, ack, vx} seen in link domain
   logic lnk_ce; // clock enable as the link sees it

   rbc_sync #(.W(1)) u_req_sync (
      .clk(CLK),
      .rst(RST),
      .d(req_tgl_q),
      .q(req_sync)
   );

   rbc_sync #(.W(3)) u_lnk_sync (
      .clk(SCK),
      .rst(RST),
      .d({CE, ack_tgl_q, vx_tgl_q}),
      .q(to_lnk)
   );
   assign lnk_ce = to_lnk[2];

   ////////////////////////////////////////////////////////////////////////////
   // CLK domain: stored register, working copy, write enable latch
   logic [7:0] nv_q, nv_d; // stored boot configuration
   logic [7:0] vol_q, vol_d; // working copy that governs reads
   logic wel_q, wel_d; // write enable latch
   logic req_seen_q, req_seen_d; // last handled request toggle
   logic ack_tgl_d, vx_tgl_d;
   logic [7:0] lnk_op_q; // opcode held by link side while busy
   logic [7:0] lnk_wd_q; // write data held by link side while busy
   logic cmd_new; // a held command has just arrived

   // link holds op/data steady until the ack returns, so sampling is safe
   always_comb begin
      cmd_new = req_sync != req_seen_q;
      nv_d = nv_q;
      vol_d = vol_q;
      wel_d = wel_q;
      req_seen_d = req_sync;
      ack_tgl_d = ack_tgl_q;
      vx_tgl_d = vx_tgl_q;
      if (cmd_new) begin
         ack_tgl_d = ~ack_tgl_q;
         if (lnk_op_q == rbc_pkg::OP_NV_NV_WRITE_ENABLE_CMD) begin
            wel_d = 1'b1;
         end else if ((lnk_op_q == rbc_pkg::OP_WRITE_REGS) ||
                      (lnk_op_q == rbc_pkg::OP_WRITE_ANY)) begin
            // writes without a prior enable are dropped
            if (wel_q) begin
               nv_d = lnk_wd_q;
               nv_d[rbc_pkg::RSV_BIT] = 1'b0;
            end
            wel_d = 1'b0;
         end
      end
      // hardware or software reset reloads the working copy
      if (RELOAD) begin
         vol_d = nv_q;
         vx_tgl_d = ~vx_tgl_q;
      end
   end

   // power-on: stored value takes factory content, working copy follows it
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         nv_q <= rbc_pkg::NV_RESET;
         vol_q <= rbc_pkg::NV_RESET;
         wel_q <= 1'b0;
         req_seen_q <= 1'b0;
         ack_tgl_q <= 1'b0;
         vx_tgl_q <= 1'b0;
      end else if (CE) begin
         nv_q <= nv_d;
         vol_q <= vol_d;
         wel_q <= wel_d;
         req_seen_q <= req_seen_d;
         ack_tgl_q <= ack_tgl_d;
         vx_tgl_q <= vx_tgl_d;
      end
   end

   // status outputs from flops; wrap enable and wrap bytes decoded from the working copy
   assign REG_RDATA = nv_q;
   assign WRAP_ENABLE = ~vol_q[rbc_pkg::WE_BIT];
   assign WRAP_BYTES = rbc_pkg::WRAP_BASE << vol_q[rbc_pkg::WL_HI:rbc_pkg::WL_LO];
   assign READ_LATENCY = vol_q[rbc_pkg::RL_HI:rbc_pkg::RL_LO];
   assign WRITE_ENABLED = wel_q;

   ////////////////////////////////////////////////////////////////////////////
   // link domain: command capture, latency figures, dummy counter
   logic [7:0] lnk_op_d, lnk_wd_d;
   logic req_tgl_d;
   logic busy_q, busy_d; // a register command is in flight
   logic ack_seen_q, ack_seen_d;
   logic vx_seen_q, vx_seen_d;
   logic [7:0] lvol_q, lvol_d; // link copy of the working register
   logic [4:0] dum_q, dum_d;
   logic [2:0] mode_q, mode_d;
   logic wrap_q, wrap_d;
   logic [6:0] wbytes_q, wbytes_d;
   logic [4:0] cnt_q, cnt_d; // dummy cycles still to run
   logic go_q, go_d;
   logic [3:0] code; // latency code in the link copy
   logic is_reg_cmd;

   // figures for a read are fixed at opcode time from the link copy
   always_comb begin
      code = lvol_q[rbc_pkg::RL_HI:rbc_pkg::RL_LO];
      is_reg_cmd = (LNK_OPCODE == rbc_pkg::OP_NV_NV_WRITE_ENABLE_CMD) ||
                   (LNK_OPCODE == rbc_pkg::OP_WRITE_REGS) ||
                   (LNK_OPCODE == rbc_pkg::OP_WRITE_ANY);
      lnk_op_d = lnk_op_q;
      lnk_wd_d = lnk_wd_q;
      req_tgl_d = req_tgl_q;
      busy_d = busy_q;
      ack_seen_d = to_lnk[1];
      vx_seen_d = to_lnk[0];
      lvol_d = lvol_q;
      dum_d = dum_q;
      mode_d = mode_q;
      wrap_d = wrap_q;
      wbytes_d = wbytes_q;
      cnt_d = cnt_q;
      go_d = 1'b0;
      // ack returns: release the held command
      if (to_lnk[1] != ack_seen_q) begin
         busy_d = 1'b0;
      end
      // working copy changed: vol_q is stable by the time the toggle lands
      if (to_lnk[0] != vx_seen_q) begin
         lvol_d = vol_q;
      end
      if (LNK_CMD_VALID) begin
         // register commands arriving while busy are refused
         if (is_reg_cmd && !busy_q) begin
            lnk_op_d = LNK_OPCODE;
            lnk_wd_d = LNK_WDATA;
            req_tgl_d = ~req_tgl_q;
            busy_d = 1'b1;
         end
         mode_d = rbc_pkg::MODE_NONE;
         dum_d = rbc_pkg::DUMMY_NONE;
         case (LNK_OPCODE)
            rbc_pkg::OP_LEARN_READ, rbc_pkg::OP_PROT_BITS_READ,
            rbc_pkg::OP_PROT_REG_READ, rbc_pkg::OP_PASSWORD_READ: begin
               dum_d = rbc_pkg::DUMMY_FIXED;
            end
            rbc_pkg::OP_FAST_READ, rbc_pkg::OP_DUAL_OUT, rbc_pkg::OP_QUAD_OUT,
            rbc_pkg::OP_SEC_READ, rbc_pkg::OP_READ_ANY, rbc_pkg::OP_PARAM_READ,
            rbc_pkg::OP_DUAL_IO, rbc_pkg::OP_QUAD_IO, rbc_pkg::OP_DDR_QUAD_IO: begin
               dum_d = (code == 4'h0) ? rbc_pkg::DUMMY_CODE0 : {1'b0, code};
            end
            default: begin
               dum_d = rbc_pkg::DUMMY_NONE;
            end
         endcase
         // mode cycles are counted apart from the latency
         case (LNK_OPCODE)
            rbc_pkg::OP_DUAL_IO: mode_d = rbc_pkg::MODE_DUAL_IO;
            rbc_pkg::OP_QUAD_IO: mode_d = rbc_pkg::MODE_QUAD_IO;
            rbc_pkg::OP_DDR_QUAD_IO: mode_d = rbc_pkg::MODE_DDR;
            default: mode_d = rbc_pkg::MODE_NONE;
         endcase
         // quad io opcodes cover both the SDR and DDR quad io forms
         wrap_d = ~lvol_q[rbc_pkg::WE_BIT] &&
                  ((LNK_OPCODE == rbc_pkg::OP_QUAD_IO) ||
                   (LNK_OPCODE == rbc_pkg::OP_DDR_QUAD_IO));
         wbytes_d = rbc_pkg::WRAP_BASE << lvol_q[rbc_pkg::WL_HI:rbc_pkg::WL_LO];
      end
      // latency starts after the last address or mode cycle
      if (LNK_ADDR_DONE) begin
         cnt_d = dum_q;
         go_d = (dum_q == rbc_pkg::DUMMY_NONE);
      end else if (cnt_q != rbc_pkg::DUMMY_NONE) begin
         cnt_d = cnt_q - 5'h01;
         go_d = (cnt_q == rbc_pkg::DUMMY_FIXED);
      end
   end

   // link registers, frozen with the synchronised clock enable
   always_ff @(posedge SCK or posedge RST) begin
      if (RST) begin
         lnk_op_q <= 8'h00;
         lnk_wd_q <= 8'h00;
         req_tgl_q <= 1'b0;
         busy_q <= 1'b0;
         ack_seen_q <= 1'b0;
         vx_seen_q <= 1'b0;
         lvol_q <= rbc_pkg::NV_RESET;
         dum_q <= rbc_pkg::DUMMY_NONE;
         mode_q <= rbc_pkg::MODE_NONE;
         wrap_q <= 1'b0;
         wbytes_q <= rbc_pkg::WRAP_BASE;
         cnt_q <= rbc_pkg::DUMMY_NONE;
         go_q <= 1'b0;
      end else if (lnk_ce) begin
         lnk_op_q <= lnk_op_d;
         lnk_wd_q <= lnk_wd_d;
         req_tgl_q <= req_tgl_d;
         busy_q <= busy_d;
         ack_seen_q <= ack_seen_d;
         vx_seen_q <= vx_seen_d;
         lvol_q <= lvol_d;
         dum_q <= dum_d;
         mode_q <= mode_d;
         wrap_q <= wrap_d;
         wbytes_q <= wbytes_d;
         cnt_q <= cnt_d;
         go_q <= go_d;
      end
   end

   assign LNK_BUSY = busy_q;
   assign LNK_DUMMY = dum_q;
   assign LNK_MODE = mode_q;
   assign LNK_WRAP = wrap_q;
   assign LNK_WRAP_BYTES = wbytes_q;
   assign LNK_DATA_GO = go_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_reload;
      CE && RELOAD;
   endsequence

   chk_reload_copies: assert property (@(posedge CLK) disable iff (RST)
      s_reload |=> (vol_q == $past(nv_q))) else $error("reload did not copy stored value");

   // quad io wrap must follow the enable bit of the link copy, zero meaning on
   chk_wrap_enable_pol: assert property (@(posedge SCK) disable iff (RST)
      (lnk_ce && LNK_CMD_VALID && LNK_OPCODE == rbc_pkg::OP_QUAD_IO)
      |=> (LNK_WRAP == !$past(lvol_q[rbc_pkg::WE_BIT]))) else $error("wrap enable polarity wrong");

   chk_wrap_len_map: assert property (@(posedge CLK) disable iff (RST)
      (vol_q[6:5] == 2'b11) |-> (WRAP_BYTES == 7'h40)) else $error("wrap length code 3 not 64");

   chk_latency_out: assert property (@(posedge CLK) disable iff (RST)
      s_reload |=> (READ_LATENCY == $past(nv_q[3:0]))) else $error("latency not reloaded");

   // the latch clears on the same edge as the write lands, so look one cycle back
   chk_write_needs_en: assert property (@(posedge CLK) disable iff (RST)
      $changed(nv_q) |-> $past(wel_q)) else $error("stored value changed without enable");

   chk_reserved_zero: assert property (@(posedge CLK) disable iff (RST)
      $changed(nv_q) |-> !nv_q[7]) else $error("reserved bit written as one");

   chk_fixed_one: assert property (@(posedge SCK) disable iff (RST)
      (lnk_ce && LNK_CMD_VALID && LNK_OPCODE == rbc_pkg::OP_PASSWORD_READ)
      |=> (LNK_DUMMY == 5'h01)) else $error("register read not one dummy");

   chk_code0_eight: assert property (@(posedge SCK) disable iff (RST)
      (lnk_ce && LNK_CMD_VALID && LNK_OPCODE == rbc_pkg::OP_FAST_READ && code == 4'h0)
      |=> (LNK_DUMMY == 5'h08)) else $error("code zero not eight dummies");

   chk_wrap_only_quad: assert property (@(posedge SCK) disable iff (RST)
      (lnk_ce && LNK_CMD_VALID && LNK_OPCODE == rbc_pkg::OP_FAST_READ) |=> !LNK_WRAP)
      else $error("wrap on non quad read");

   chk_mode_quad_io: assert property (@(posedge SCK) disable iff (RST)
      (lnk_ce && LNK_CMD_VALID && LNK_OPCODE == rbc_pkg::OP_QUAD_IO) |=> (LNK_MODE == 3'h2))
      else $error("quad io mode cycles wrong");

   // eight dummy cycles run after the address edge; go is registered one edge later
   sequence s_eight_dummies;
      (lnk_ce && LNK_ADDR_DONE && dum_q == 5'h08) ##1 (lnk_ce && !LNK_ADDR_DONE)[*8];
   endsequence

   chk_go_after_dummy: assert property (@(posedge SCK) disable iff (RST)
      s_eight_dummies |=> LNK_DATA_GO) else $error("data start not after latency");
endmodule

// File: rbc_pkg.sv
package rbc_pkg;
   // factory content of the boot config register
   localparam logic [7:0] NV_RESET = 8'h78;
   // field positions
   localparam int RSV_BIT = 7;
   localparam int WL_HI = 6;
   localparam int WL_LO = 5;
   localparam int WE_BIT = 4;
   localparam int RL_HI = 3;
   localparam int RL_LO = 0;
   // command opcodes
   localparam logic [7:0] OP_NV_NV_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] OP_WRITE_REGS = 8'h01;
   localparam logic [7:0] OP_WRITE_ANY = 8'h71;
   localparam logic [7:0] OP_READ_ANY = 8'h65;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
   localparam logic [7:0] OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_QUAD_IO = 8'hEB;
   localparam logic [7:0] OP_DDR_QUAD_IO = 8'hED;
   localparam logic [7:0] OP_SEC_READ = 8'h4B;
   localparam logic [7:0] OP_PARAM_READ = 8'h5A;
   localparam logic [7:0] OP_LEARN_READ = 8'h41;
   localparam logic [7:0] OP_PROT_BITS_READ = 8'h2B;
   localparam logic [7:0] OP_PROT_REG_READ = 8'hA7;
   localparam logic [7:0] OP_PASSWORD_READ = 8'hE7;
   // latency figures
   localparam logic [4:0] DUMMY_CODE0 = 5'h08;
   localparam logic [4:0] DUMMY_FIXED = 5'h01;
   localparam logic [4:0] DUMMY_NONE = 5'h00;
   localparam logic [2:0] MODE_DUAL_IO = 3'h4;
   localparam logic [2:0] MODE_QUAD_IO = 3'h2;
   localparam logic [2:0] MODE_DDR = 3'h1;
   localparam logic [2:0] MODE_NONE = 3'h0;
   // smallest wrap group in bytes
   localparam logic [6:0] WRAP_BASE = 7'h08;
endpackage

// File: rbc_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser, one per bit; the first stage feeds only the second
module rbc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q; // first stage, read by the second stage only
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   // next values: plain shift
   always_comb begin
      meta_d = d;
      q_d = meta_q;
   end

   // register both stages
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule

// File: rbc_host.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// spi host model; the link clock only toggles inside its own tasks
module rbc_host (
   output logic sck,
   output logic cmd_valid,
   output logic [7:0] opcode,
   output logic [7:0] wdata,
   output logic addr_done,
   input wire logic busy,
   input wire logic data_go
);
   // 15 ns period, about 66 MHz, within every code used for the reads here
   localparam real HALF = 7.5;
   // idle lines at time zero
   initial begin
      sck = 1'b0;
      cmd_valid = 1'b0;
      opcode = 8'h00;
      wdata = 8'h00;
      addr_done = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // link cycles; inputs only move in the low phase, far from the sampling edge
   task automatic tick(input int n);
      repeat (n) begin
         #HALF sck = 1'b1;
         #HALF sck = 1'b0;
      end
   endtask
   // one command frame; released lines show the inverse, not a stale value
   task automatic cmd(input logic [7:0] op, input logic [7:0] dat);
      cmd_valid = 1'b1;
      opcode = op;
      wdata = dat;
      tick(1);
      cmd_valid = 1'b0;
      opcode = ~op;
      wdata = ~dat;
      tick(1);
   endtask
   // register commands are paced by busy, bounded so a hang cannot stall us
   task automatic wait_idle();
      int cnt;
      cnt = 0;
      while (busy !== 1'b0 && cnt < 60) begin
         tick(1);
         cnt++;
      end
   endtask
   // address and mode done: from here on the host only clocks and watches data_go
   task automatic latency(output int cnt);
      addr_done = 1'b1;
      tick(1);
      addr_done = 1'b0;
      cnt = 0;
      while (data_go !== 1'b1 && cnt < 40) begin
         tick(1);
         cnt++;
      end
   endtask
endmodule

// File: tb_read_boot_config_nv_register.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
   $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module tb_read_boot_config_nv_register;
   logic CLK;
   logic CE;
   logic RST;
   logic RELOAD;
   logic sck, cmd_valid, addr_done, busy, data_go;
   logic [7:0] opcode, wdata, rdata;
   logic [4:0] dummy;
   logic [2:0] mode;
   logic lwrap, wrap_en, wr_en;
   logic [6:0] lbytes, wbytes;
   logic [3:0] rlat;
   int errors;
   int check_count;
   int n;
   // read opcodes: first nine follow the code, last four are register reads
   logic [7:0] ops [13] = '{8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hED, 8'h4B, 8'h5A,
      8'h65, 8'h41, 8'h2B, 8'hA7, 8'hE7};
   // clock enable is driven so that one test can freeze the block
   rbc_top dut_u (.CLK(CLK), .RST(RST), .CE(CE), .RELOAD(RELOAD), .SCK(sck),
      .LNK_CMD_VALID(cmd_valid), .LNK_OPCODE(opcode), .LNK_WDATA(wdata),
      .LNK_ADDR_DONE(addr_done), .LNK_BUSY(busy), .LNK_DUMMY(dummy), .LNK_MODE(mode),
      .LNK_WRAP(lwrap), .LNK_WRAP_BYTES(lbytes), .LNK_DATA_GO(data_go),
      .REG_RDATA(rdata), .WRAP_ENABLE(wrap_en), .WRAP_BYTES(wbytes),
      .READ_LATENCY(rlat), .WRITE_ENABLED(wr_en));
   rbc_host host_u (.sck(sck), .cmd_valid(cmd_valid), .opcode(opcode), .wdata(wdata),
      .addr_done(addr_done), .busy(busy), .data_go(data_go));
   ////////////////////////////////////////////////////////////////////////////
   // system clock, 100 MHz
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // single place where the run ends
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // hardware or software reset pulse, then let the link copy catch up
   task automatic reload();
      @(posedge CLK) RELOAD <= 1'b1;
      @(posedge CLK) RELOAD <= 1'b0;
      repeat (3) @(negedge CLK);
      host_u.tick(4);
   endtask
   // enable then write; the latch must drop once the write lands
   task automatic wr_reg(input logic [7:0] op, input logic [7:0] dat);
      host_u.cmd(8'h06, 8'h00);
      host_u.wait_idle();
      repeat (3) @(negedge CLK);
      `CHK("enable busy", 1'b0, busy)
      `CHK("write_enabled", 1'b1, wr_en)
      host_u.cmd(op, dat);
      host_u.wait_idle();
      repeat (3) @(negedge CLK);
      `CHK("write busy", 1'b0, busy)
      `CHK("reg_rdata", dat, rdata)
      `CHK("write_enabled", 1'b0, wr_en)
   endtask
   // every read opcode against the figures the code should give
   task automatic chk_ops(input logic [3:0] code, input logic won, input logic [6:0] wb);
      logic [4:0] ed;
      for (int i = 0; i < 13; i++) begin
         host_u.cmd(ops[i], 8'h00);
         ed = (i > 8) ? 5'h01 : ((code == 4'h0) ? 5'h08 : {1'b0, code});
         `CHK("lnk_dummy", ed, dummy)
         `CHK("lnk_mode", (i == 3) ? 3'h4 : (i == 4) ? 3'h2 : (i == 5) ? 3'h1 : 3'h0, mode)
         `CHK("lnk_wrap", won & (i == 4 || i == 5), lwrap)
         `CHK("lnk_wrap_bytes", wb, lbytes)
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the few microseconds the tests need
   initial begin
      #200000;
      errors++;
      end_sim();
   end
   // main sequence
   initial begin
      RST = 1'b1;
      RELOAD = 1'b0;
      CE = 1'b1;
      errors = 0;
      check_count = 0;
      host_u.tick(2);
      repeat (20) @(posedge CLK);
      @(negedge CLK);
      `CHK("rst rdata", 8'h78, rdata)
      `CHK("rst wrap_en", 1'b0, wrap_en)
      `CHK("rst wbytes", 7'h40, wbytes)
      `CHK("rst rlat", 4'h8, rlat)
      `CHK("rst wr_en", 1'b0, wr_en)
      @(posedge CLK) RST <= 1'b0;
      host_u.tick(3);
      $display("test reset done");
      // a write without the enable must leave the register alone
      host_u.cmd(8'h71, 8'h40);
      host_u.wait_idle();
      repeat (4) @(negedge CLK);
      `CHK("refused busy", 1'b0, busy)
      `CHK("unenabled write", 8'h78, rdata)
      $display("test refused write done");
      // 32-byte wrap on, code zero
      wr_reg(8'h71, 8'h40);
      reload();
      `CHK("wrap_en", 1'b1, wrap_en)
      `CHK("wbytes", 7'h20, wbytes)
      `CHK("rlat", 4'h0, rlat)
      chk_ops(4'h0, 1'b1, 7'h20);
      host_u.cmd(8'hEB, 8'h00);
      host_u.latency(n);
      `CHK("quad io latency", 8, n)
      host_u.cmd(8'h41, 8'h00);
      host_u.latency(n);
      `CHK("learning latency", 1, n)
      $display("test code zero done");
      // 16-byte length, wrap off, code five, written with the other command
      wr_reg(8'h01, 8'h35);
      // a reload while the block is frozen must leave the working copy alone
      @(posedge CLK) CE <= 1'b0;
      reload();
      `CHK("frozen rlat", 4'h0, rlat)
      `CHK("frozen wbytes", 7'h20, wbytes)
      @(posedge CLK) CE <= 1'b1;
      reload();
      `CHK("wrap_en", 1'b0, wrap_en)
      `CHK("wbytes", 7'h10, wbytes)
      `CHK("rlat", 4'h5, rlat)
      chk_ops(4'h5, 1'b0, 7'h10);
      host_u.cmd(8'h0B, 8'h00);
      host_u.latency(n);
      `CHK("fast latency", 5, n)
      $display("test code five done");
      end_sim();
   end
endmodule
